//--- design/term_decoder_regs.svh
// register offsets, field positions, reset values and timing counts of the terminal decoder
`ifndef TERM_DECODER_REGS_SVH
`define TERM_DECODER_REGS_SVH

// byte offsets on the register bus
`define REG_FUNC_MAP 5'h00
`define REG_PULSE_CFG 5'h04
`define REG_CMD_STATUS 5'h08
`define REG_IRQ_STATUS 5'h0c
`define REG_IRQ_MASK 5'h10
`define REG_FREQ_OFFSET 5'h14

// field layout
`define TERM_COUNT 8
`define CODE_WIDTH 4
`define PULSE_MODE_BIT 0
`define PULSE_USE_LSB 1
`define IRQ_EXT_FAULT 0
`define IRQ_FAULT_RESET 1
`define IRQ_COAST 2
`define IRQ_DUP_CODE 3
`define IRQ_WIDTH 4

// reset values
`define FUNC_MAP_RST 32'h0000_0000
`define PULSE_CFG_RST 3'h0
`define IRQ_MASK_RST 4'h0

// timing: one up/down step every this many ns, at a core clock period in ns
`define UPDN_STEP_NS 1000000
`define CORE_CLK_NS 25

// limits of the up/down offset
`define OFFSET_MAX 16'sh7fff
`define OFFSET_MIN (-16'sh7fff)

`endif

//--- design/term_decoder_pkg.sv
// types shared by the terminal decoder modules
package term_decoder_pkg;

	// function codes a terminal may carry
	typedef enum logic [3:0] {
		FN_NONE = 4'h0,
		FN_FWD_RUN = 4'h1,
		FN_REV_RUN = 4'h2,
		FN_THREE_WIRE = 4'h3,
		FN_JOG_FWD = 4'h4,
		FN_JOG_REV = 4'h5,
		FN_COAST = 4'h6,
		FN_FAULT_RESET = 4'h7,
		FN_PAUSE = 4'h8,
		FN_EXT_FAULT = 4'h9,
		FN_FREQ_UP = 4'ha,
		FN_FREQ_DOWN = 4'hb,
		FN_FREQ_CLEAR = 4'hc
	} func_code_type;

	// use of the pulse train in pulse mode
	typedef enum logic [1:0] {
		PULSE_FREQ_REF = 2'h0,
		PULSE_COUNT = 2'h1,
		PULSE_LENGTH = 2'h2,
		PULSE_UNUSED = 2'h3
	} pulse_use_type;

	// register bus slave states
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK = 2'b10
	} bus_state_type;

endpackage : term_decoder_pkg

//--- design/input_sync.sv
// two-stage synchroniser for a group of pin levels
module input_sync #(
	parameter int WIDTH = 1
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] level_out
);

	logic [WIDTH-1:0] meta_q;

	// first stage feeds only the second stage
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			meta_q <= '0;
			level_out <= '0;
		end else if (clk_en) begin
			meta_q <= pin_in;
			level_out <= meta_q;
		end
	end

endmodule : input_sync

//--- design/input_terminal_function_decoder.sv
// programmable digital input terminal decoder with register bus and interrupt
// Notes on behaviour
// - eight terminals, each with its function code
// - open-collector input: switch or pulse mode
// - pulse mode feeds frequency, count or length
// - code zero does nothing at any level
// - codes one, two run forward, reverse
// - code three selects three-wire run control
// - codes four, five jog forward, reverse
// - code six disables drive output at once
// - code seven resets latched fault
// - code eight pauses, keeping running state
// - code nine latches external fault, stops running
// - codes ten, eleven step frequency up, down
// - code twelve clears up/down offset
//
// The register addresses and the Avalon-MM slave port are this design's own decisions.
`include "term_decoder_regs.svh"

module input_terminal_function_decoder
	import term_decoder_pkg::*;
#(
	parameter int UPDN_STEP_CYCLES = `UPDN_STEP_NS / `CORE_CLK_NS
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic [7:0] terminal_in,
	input wire logic pulse_capable_input,
	input wire logic [4:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	output logic forward_run_command,
	output logic reverse_run_command,
	output logic three_wire_mode,
	output logic jog_forward,
	output logic jog_reverse,
	output logic output_disable,
	output logic fault_reset_pulse,
	output logic pause_hold,
	output logic external_fault,
	output logic signed [15:0] freq_offset,
	output logic pulse_switch_level,
	output logic pulse_freq_ref,
	output logic pulse_count,
	output logic pulse_length,
	output logic irq
);

	// true when any active terminal carries the given code
	function automatic logic code_active(input logic [7:0] lvl, input logic [31:0] map, input func_code_type code);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < `TERM_COUNT; i++) begin
			if (lvl[i] && map[i*`CODE_WIDTH +: `CODE_WIDTH] == code) begin
				hit = 1'b1;
			end
		end
		return hit;
	endfunction : code_active

	// true when two terminals share a code other than none
	function automatic logic code_duplicated(input logic [31:0] map);
		logic dup;
		dup = 1'b0;
		for (int i = 0; i < `TERM_COUNT; i++) begin
			for (int j = i + 1; j < `TERM_COUNT; j++) begin
				if (map[i*`CODE_WIDTH +: `CODE_WIDTH] != FN_NONE &&
						map[i*`CODE_WIDTH +: `CODE_WIDTH] == map[j*`CODE_WIDTH +: `CODE_WIDTH]) begin
					dup = 1'b1;
				end
			end
		end
		return dup;
	endfunction : code_duplicated

	logic [31:0] func_map_q;
	logic [2:0] pulse_cfg_q;
	logic [3:0] irq_status_q;
	logic [3:0] irq_mask_q;
	logic [3:0] irq_set;
	bus_state_type bus_state_q;
	logic [7:0] term_lvl;
	logic pulse_lvl;
	logic fwd_hit, rev_hit, three_hit, jogf_hit, jogr_hit, coast_hit;
	logic reset_hit, pause_hit, ext_hit, up_hit, down_hit, clear_hit;
	logic reset_prev_q, ext_prev_q, coast_prev_q;
	logic reset_rise, ext_rise, coast_rise;
	logic [31:0] step_cnt_q;
	logic step_tick;
	logic bus_write;
	logic [31:0] read_word;

	input_sync #(.WIDTH(`TERM_COUNT + 1)) u_sync (
		.core_clk(core_clk),
		.rst(rst),
		.clk_en(clk_en),
		.pin_in({pulse_capable_input, terminal_in}),
		.level_out({pulse_lvl, term_lvl})
	);

	always_comb begin
		fwd_hit = code_active(term_lvl, func_map_q, FN_FWD_RUN);
		rev_hit = code_active(term_lvl, func_map_q, FN_REV_RUN);
		three_hit = code_active(term_lvl, func_map_q, FN_THREE_WIRE);
		jogf_hit = code_active(term_lvl, func_map_q, FN_JOG_FWD);
		jogr_hit = code_active(term_lvl, func_map_q, FN_JOG_REV);
		coast_hit = code_active(term_lvl, func_map_q, FN_COAST);
		reset_hit = code_active(term_lvl, func_map_q, FN_FAULT_RESET);
		pause_hit = code_active(term_lvl, func_map_q, FN_PAUSE);
		ext_hit = code_active(term_lvl, func_map_q, FN_EXT_FAULT);
		up_hit = code_active(term_lvl, func_map_q, FN_FREQ_UP);
		down_hit = code_active(term_lvl, func_map_q, FN_FREQ_DOWN);
		clear_hit = code_active(term_lvl, func_map_q, FN_FREQ_CLEAR);
	end

	// edge detection of event functions
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			reset_prev_q <= 1'b0;
			ext_prev_q <= 1'b0;
			coast_prev_q <= 1'b0;
		end else if (clk_en) begin
			reset_prev_q <= reset_hit;
			ext_prev_q <= ext_hit;
			coast_prev_q <= coast_hit;
		end
	end

	assign reset_rise = reset_hit & ~reset_prev_q;
	assign ext_rise = ext_hit & ~ext_prev_q;
	assign coast_rise = coast_hit & ~coast_prev_q;

	// external fault latch, set wins over reset
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			external_fault <= 1'b0;
			fault_reset_pulse <= 1'b0;
		end else if (clk_en) begin
			fault_reset_pulse <= reset_rise;
			if (ext_rise) begin
				external_fault <= 1'b1;
			end else if (reset_rise) begin
				external_fault <= 1'b0;
			end
		end
	end

	// pause holds state, run commands kept
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			forward_run_command <= 1'b0;
			reverse_run_command <= 1'b0;
			three_wire_mode <= 1'b0;
			jog_forward <= 1'b0;
			jog_reverse <= 1'b0;
			output_disable <= 1'b0;
			pause_hold <= 1'b0;
		end else if (clk_en) begin
			forward_run_command <= fwd_hit & ~external_fault & ~ext_rise;
			reverse_run_command <= rev_hit & ~external_fault & ~ext_rise;
			three_wire_mode <= three_hit;
			jog_forward <= jogf_hit & ~external_fault & ~ext_rise;
			jog_reverse <= jogr_hit & ~external_fault & ~ext_rise;
			output_disable <= coast_hit;
			pause_hold <= pause_hit;
		end
	end

	// step timer for up/down stepping
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			step_cnt_q <= 32'h0000_0000;
		end else if (clk_en) begin
			if (!(up_hit ^ down_hit) || step_tick) begin
				step_cnt_q <= 32'h0000_0000;
			end else begin
				step_cnt_q <= step_cnt_q + 32'h0000_0001;
			end
		end
	end

	assign step_tick = (up_hit ^ down_hit) && step_cnt_q == 32'(UPDN_STEP_CYCLES - 1);

	// offset steps up or down, saturating
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			freq_offset <= 16'sh0000;
		end else if (clk_en) begin
			if (clear_hit) begin
				freq_offset <= 16'sh0000;
			end else if (step_tick && up_hit && freq_offset != `OFFSET_MAX) begin
				freq_offset <= freq_offset + 16'sh0001;
			end else if (step_tick && down_hit && freq_offset != `OFFSET_MIN) begin
				freq_offset <= freq_offset - 16'sh0001;
			end
		end
	end

	// route pulse train to its use
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pulse_switch_level <= 1'b0;
			pulse_freq_ref <= 1'b0;
			pulse_count <= 1'b0;
			pulse_length <= 1'b0;
		end else if (clk_en) begin
			pulse_switch_level <= pulse_lvl & ~pulse_cfg_q[`PULSE_MODE_BIT];
			pulse_freq_ref <= pulse_lvl & pulse_cfg_q[`PULSE_MODE_BIT] &
				(pulse_cfg_q[`PULSE_USE_LSB +: 2] == PULSE_FREQ_REF);
			pulse_count <= pulse_lvl & pulse_cfg_q[`PULSE_MODE_BIT] &
				(pulse_cfg_q[`PULSE_USE_LSB +: 2] == PULSE_COUNT);
			pulse_length <= pulse_lvl & pulse_cfg_q[`PULSE_MODE_BIT] &
				(pulse_cfg_q[`PULSE_USE_LSB +: 2] == PULSE_LENGTH);
		end
	end

	// bus handshake: one wait cycle, then answer
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			bus_state_q <= BUS_IDLE;
		end else if (clk_en) begin
			case (bus_state_q)
				BUS_IDLE: begin
					if (read || write) begin
						bus_state_q <= BUS_ACK;
					end
				end
				BUS_ACK: begin
					bus_state_q <= BUS_IDLE;
				end
				default: begin
					bus_state_q <= BUS_IDLE;
				end
			endcase
		end
	end

	assign waitrequest = !(bus_state_q == BUS_ACK && clk_en);
	assign bus_write = write && bus_state_q == BUS_ACK && clk_en;

	// read mux, unmapped reads as zero
	always_comb begin
		case (address)
			`REG_FUNC_MAP: read_word = func_map_q;
			`REG_PULSE_CFG: read_word = {29'h0, pulse_cfg_q};
			`REG_CMD_STATUS: read_word = {12'h000, pulse_lvl, term_lvl, up_hit, down_hit, clear_hit,
				external_fault, pause_hold, output_disable, jog_reverse, jog_forward,
				three_wire_mode, reverse_run_command, forward_run_command};
			`REG_IRQ_STATUS: read_word = {28'h0, irq_status_q};
			`REG_IRQ_MASK: read_word = {28'h0, irq_mask_q};
			`REG_FREQ_OFFSET: read_word = {16'h0000, freq_offset};
			default: read_word = 32'h0000_0000;
		endcase
	end

	// read data captured at the edge that sees the read in the idle state, one cycle before the answer
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			readdata <= 32'h0000_0000;
		end else if (clk_en && bus_state_q == BUS_IDLE && read) begin
			readdata <= read_word;
		end
	end

	// function map and pulse configuration writes
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			func_map_q <= `FUNC_MAP_RST;
			pulse_cfg_q <= `PULSE_CFG_RST;
			irq_mask_q <= `IRQ_MASK_RST;
		end else if (bus_write) begin
			if (address == `REG_FUNC_MAP) begin
				for (int b = 0; b < 4; b++) begin
					if (byteenable[b]) begin
						func_map_q[b*8 +: 8] <= writedata[b*8 +: 8];
					end
				end
			end
			if (address == `REG_PULSE_CFG && byteenable[0]) begin
				pulse_cfg_q <= writedata[2:0];
			end
			if (address == `REG_IRQ_MASK && byteenable[0]) begin
				irq_mask_q <= writedata[3:0];
			end
		end
	end

	assign irq_set = {code_duplicated(func_map_q), coast_rise, reset_rise, ext_rise};

	// sticky events, write one to clear, set wins
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			irq_status_q <= 4'h0;
		end else if (clk_en) begin
			if (bus_write && address == `REG_IRQ_STATUS && byteenable[0]) begin
				irq_status_q <= (irq_status_q & ~writedata[3:0]) | irq_set;
			end else begin
				irq_status_q <= irq_status_q | irq_set;
			end
		end
	end

	assign irq = |(irq_status_q & irq_mask_q);

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst || !clk_en);

	a_fwd_run_decode: assert property ((fwd_hit && !external_fault && !ext_rise) |=> forward_run_command)
		else $error("forward run not commanded");
	a_fault_stops_run: assert property (external_fault |=> !forward_run_command && !reverse_run_command)
		else $error("run commanded while faulted");
	a_fault_latch_set: assert property ((ext_rise || (external_fault && !reset_rise)) |=> external_fault)
		else $error("external fault not latched");
	a_fault_reset_clear: assert property ((reset_rise && !ext_rise) |=> !external_fault && fault_reset_pulse)
		else $error("fault reset had no effect");
	a_coast_immediate: assert property (coast_hit |=> output_disable)
		else $error("coast did not disable output");
	a_offset_clear: assert property (clear_hit |=> freq_offset == 16'sh0000)
		else $error("offset not cleared");
	a_none_map_idle: assert property ((func_map_q == 32'h0000_0000) [*2] |=> !forward_run_command && !output_disable && !pause_hold)
		else $error("no-function terminal acted");
	a_pulse_route: assert property ((pulse_cfg_q == 3'h1 && pulse_lvl) |=> pulse_freq_ref && !pulse_switch_level)
		else $error("pulse not routed to frequency reference");
	a_bus_answer: assert property ((bus_state_q == BUS_IDLE && (read || write)) |=> !waitrequest ##1 waitrequest)
		else $error("bus answer not after one wait cycle");
	a_irq_ext_event: assert property ((ext_rise && irq_mask_q[`IRQ_EXT_FAULT] &&
		!(bus_write && address == `REG_IRQ_MASK)) |=> irq)
		else $error("masked-in event raised no interrupt");

endmodule : input_terminal_function_decoder

//--- tb/terminal_driver.sv
// model of the switches and controller that drive the terminal pins
module terminal_driver (
	input wire logic core_clk,
	input wire logic [7:0] level_req,
	input wire logic pulse_req,
	output logic [7:0] terminal_in = 8'h00,
	output logic pulse_capable_input = 1'b0
);
	timeunit 1ns;
	timeprecision 100ps;

	// contacts settle one edge after the bench asks, like a relay closing
	always @(posedge core_clk) begin
		terminal_in <= level_req;
		pulse_capable_input <= pulse_req;
	end
endmodule : terminal_driver

//--- tb/testbench.sv
// self-checking testbench of the input terminal function decoder
`include "term_decoder_regs.svh"
`define check_eq(got, exp, msg) begin checked++; if ((got) !== (exp)) begin miscompares++; \
	$display("unexpected %0t %s", $time, msg); end end

module testbench;
	timeunit 1ns;
	timeprecision 100ps;

	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [4:0] address = 5'h00;
	logic [31:0] writedata = 32'h0;
	logic [3:0] byteenable = 4'hf;
	logic [7:0] level_req = 8'h00;
	logic pulse_req = 1'b0;
	logic [31:0] rdata;
	wire logic [7:0] terminal_in;
	wire logic pulse_capable_input;
	logic [31:0] readdata;
	logic waitrequest, forward_run_command, reverse_run_command, three_wire_mode, jog_forward, jog_reverse;
	logic output_disable, fault_reset_pulse, pause_hold, external_fault, irq;
	logic pulse_switch_level, pulse_freq_ref, pulse_count, pulse_length;
	logic signed [15:0] freq_offset;
	logic [8:0] cmds;
	logic [3:0] pouts;
	int miscompares = 0;
	int checked = 0;

	// command outputs in function code order, code 1 at bit 0
	assign cmds = {external_fault, pause_hold, fault_reset_pulse, output_disable, jog_reverse, jog_forward,
		three_wire_mode, reverse_run_command, forward_run_command};
	assign pouts = {pulse_length, pulse_count, pulse_freq_ref, pulse_switch_level};

	// short up/down step keeps the run brief
	input_terminal_function_decoder #(.UPDN_STEP_CYCLES(4)) dut (.core_clk(core_clk), .rst(rst), .clk_en(1'b1),
		.terminal_in(terminal_in), .pulse_capable_input(pulse_capable_input), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .forward_run_command(forward_run_command),
		.reverse_run_command(reverse_run_command), .three_wire_mode(three_wire_mode), .jog_forward(jog_forward),
		.jog_reverse(jog_reverse), .output_disable(output_disable), .fault_reset_pulse(fault_reset_pulse),
		.pause_hold(pause_hold), .external_fault(external_fault), .freq_offset(freq_offset),
		.pulse_switch_level(pulse_switch_level), .pulse_freq_ref(pulse_freq_ref), .pulse_count(pulse_count),
		.pulse_length(pulse_length), .irq(irq));

	terminal_driver partner (.core_clk(core_clk), .level_req(level_req), .pulse_req(pulse_req),
		.terminal_in(terminal_in), .pulse_capable_input(pulse_capable_input));

	// 25 ns clock
	initial begin
		forever #12.5 core_clk = ~core_clk;
	end

	// one bus access, held until waitrequest is seen low at a rising edge
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
		int n;
		n = 0;
		@(posedge core_clk);
		read <= ~wr;
		write <= wr;
		address <= a;
		writedata <= d;
		byteenable <= be;
		// waitrequest and read data are taken at the same rising edge
		@(posedge core_clk);
		while (waitrequest !== 1'b0 && n < 100) begin
			@(posedge core_clk);
			n++;
		end
		if (n >= 100) begin
			miscompares++;
		end
		rdata = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask : bus

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'hf);
	endtask : wr

	task automatic rd(input logic [4:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0, 4'hf);
		`check_eq(rdata, exp, "register read")
	endtask : rd

	// wait whole cycles, then look at settled outputs mid-cycle
	task automatic wait_n(input int n);
		repeat (n) @(posedge core_clk);
		@(negedge core_clk);
	endtask : wait_n

	task automatic press(input logic [7:0] m, input int n);
		@(posedge core_clk);
		level_req <= m;
		wait_n(n);
	endtask : press

	task automatic summarize();
		if (miscompares == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : summarize

	// cuts a hang short
	initial begin
		repeat (20000) @(posedge core_clk);
		miscompares++;
		summarize();
	end

	initial begin
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		rd(`REG_FUNC_MAP, 32'h0);
		rd(`REG_PULSE_CFG, 32'h0);
		rd(`REG_IRQ_MASK, 32'h0);
		rd(5'h18, 32'h0);
		wr(5'h18, 32'hffff_ffff);
		// terminal i carries code i+1, distinct codes only
		wr(`REG_FUNC_MAP, 32'h8765_4321);
		bus(1'b1, `REG_FUNC_MAP, 32'hffff_ffff, 4'h1);
		rd(`REG_FUNC_MAP, 32'h8765_43ff);
		wr(`REG_FUNC_MAP, 32'h8765_4321);
		press(8'h01, 3);
		`check_eq(cmds, 9'h000, "command before sync")
		wait_n(1);
		`check_eq(cmds, 9'h001, "forward run")
		rd(`REG_CMD_STATUS, 32'h0000_0801);
		for (int i = 1; i < 8; i++) begin
			press(8'h01 << i, 5);
			`check_eq(cmds, (i == 6) ? 9'h000 : 9'h001 << i, "level command")
		end
		press(8'h00, 5);
		`check_eq(cmds, 9'h000, "all released")
		// no function and reserved codes
		wr(`REG_FUNC_MAP, 32'h0);
		press(8'hff, 5);
		`check_eq(cmds, 9'h000, "code zero")
		wr(`REG_FUNC_MAP, 32'h0000_0fed);
		wait_n(3);
		`check_eq(cmds, 9'h000, "reserved codes")
		press(8'h00, 5);
		// external fault, reset, interrupt and mask
		wr(`REG_FUNC_MAP, 32'h0000_0719);
		wr(`REG_IRQ_STATUS, 32'hf);
		wr(`REG_IRQ_MASK, 32'h3);
		press(8'h02, 5);
		`check_eq(cmds, 9'h001, "run before fault")
		press(8'h03, 5);
		`check_eq(cmds, 9'h100, "fault stops run")
		`check_eq(irq, 1'b1, "fault interrupt")
		press(8'h02, 5);
		`check_eq(cmds, 9'h100, "fault held")
		press(8'h06, 5);
		`check_eq(cmds, 9'h001, "fault reset")
		rd(`REG_IRQ_STATUS, 32'h3);
		wr(`REG_IRQ_STATUS, 32'h3);
		rd(`REG_IRQ_STATUS, 32'h0);
		wait_n(0);
		`check_eq(irq, 1'b0, "interrupt cleared")
		wr(`REG_IRQ_MASK, 32'h0);
		press(8'h02, 5);
		press(8'h03, 5);
		`check_eq(irq, 1'b0, "masked interrupt")
		rd(`REG_IRQ_STATUS, 32'h1);
		press(8'h06, 5);
		press(8'h00, 5);
		wr(`REG_IRQ_STATUS, 32'hf);
		// duplicate code is flagged
		wr(`REG_FUNC_MAP, 32'h0000_0011);
		wait_n(3);
		rd(`REG_IRQ_STATUS, 32'h8);
		wr(`REG_IRQ_STATUS, 32'hf);
		// up, down and clear
		wr(`REG_FUNC_MAP, 32'h0000_0cba);
		press(8'h01, 25);
		`check_eq($signed(freq_offset) > 16'sd2 && $signed(freq_offset) < 16'sd8, 1'b1, "offset up")
		press(8'h04, 5);
		`check_eq(freq_offset, 16'sh0000, "offset cleared")
		press(8'h02, 25);
		`check_eq($signed(freq_offset) < -16'sd2, 1'b1, "offset down")
		press(8'h00, 5);
		rd(`REG_FREQ_OFFSET, 32'h0000_fffa);
		// open-collector input as switch, then each pulse use
		@(posedge core_clk);
		pulse_req <= 1'b1;
		wait_n(5);
		`check_eq(pouts, 4'h1, "switch input")
		for (int u = 0; u < 4; u++) begin
			wr(`REG_PULSE_CFG, 32'(u * 2 + 1));
			wait_n(2);
			`check_eq(pouts, (u == 3) ? 4'h0 : 4'(2 << u), "pulse use")
		end
		summarize();
	end
endmodule : testbench
